// File: include/rcf_pkg.sv
// Constants shared by the reset cause flag block
package rcf_pkg;
    localparam int RCF_ADDR_W = 20;
    localparam int RCF_DATA_W = 8;
    localparam int RCF_NUM_SRC = 3;
    localparam logic [19:0] RCF_ADDR = 20'hFFFA8;
    localparam int RCF_BIT_TRAP = 7;
    localparam int RCF_BIT_WDT = 4;
    localparam int RCF_BIT_LVD = 0;
    localparam logic [7:0] RCF_ILLEGAL_OPCODE = 8'hFF;
    localparam logic [2:0] RCF_FLAGS_RESET = 3'h0;
    localparam logic [7:0] RCF_RDATA_RESET = 8'h00;
    // Fill used for the bits whose value is not defined
    localparam logic [7:0] RCF_UNDEF_FILL = 8'h00;
    // Source index inside the flag vector
    localparam int RCF_SRC_LVD = 0;
    localparam int RCF_SRC_WDT = 1;
    localparam int RCF_SRC_TRAP = 2;
endpackage

// File: rtl/rcf_top.sv
// Reset cause flag register with its read port and source capture
`timescale 1ns/10ps
// Function
// - The pin reset and the power-on-clear reset clear all three flags; a read clears each flag whose source is not active in that cycle.
// - Executing opcode FFH raises an internal reset and sets bit 7, keeping the other flags.
// - A watchdog reset sets bit 4 and keeps the other two flags.
// - A low-voltage reset sets bit 0 and keeps the other two flags.
// - Bits 6, 5, 3, 2 and 1 carry no defined value and software must mask them; this block reads them as 0 (RCF_UNDEF_FILL).
// - The register is read-only at FFFA8H and its value after reset depends on the source.
// - Under a debug emulator the illegal opcode raises no reset.
module rcf_top
    import rcf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_reset_pin,
    input wire logic i_wdt_reset,
    input wire logic i_lvd_reset,
    input wire logic i_exec_valid,
    input wire logic [7:0] i_exec_opcode,
    input wire logic i_emulation,
    input wire logic [RCF_ADDR_W-1:0] i_bus_addr,
    input wire logic i_bus_rd,
    input wire logic i_bus_wr,
    output logic [RCF_DATA_W-1:0] o_bus_rdata,
    output logic o_bus_ack,
    output logic o_bus_wr_ignored,
    output logic o_trap_reset,
    output logic [RCF_NUM_SRC-1:0] o_flags
);
    logic trap;
    logic hit;
    logic rd_clear;
    logic [RCF_NUM_SRC-1:0] src_set;
    logic [RCF_NUM_SRC-1:0] flags_q;
    logic [RCF_NUM_SRC-1:0] flags_d;
    logic [RCF_DATA_W-1:0] rdata_q;
    logic [RCF_DATA_W-1:0] rdata_d;
    logic ack_q;
    logic ack_d;
    logic wr_ign_q;
    logic wr_ign_d;

    rcf_trap_detect u_trap (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_exec_valid(i_exec_valid),
        .i_exec_opcode(i_exec_opcode),
        .i_emulation(i_emulation),
        .o_trap(trap)
    );

    assign hit = (i_bus_addr == RCF_ADDR);
    assign rd_clear = i_bus_rd && hit;
    assign src_set[RCF_SRC_LVD] = i_lvd_reset;
    assign src_set[RCF_SRC_WDT] = i_wdt_reset;
    assign src_set[RCF_SRC_TRAP] = trap;

    // Each flag listens only to its own source and holds for the others
    for (genvar g = 0; g < RCF_NUM_SRC; g++) begin : g_flag
        always_comb begin
            flags_d[g] = flags_q[g];
            if (i_ce) begin
                if (i_reset_pin) begin
                    flags_d[g] = 1'b0;
                end else if (src_set[g]) begin
                    // A source event beats a read in the same cycle
                    flags_d[g] = 1'b1;
                end else if (rd_clear) begin
                    flags_d[g] = 1'b0;
                end
            end
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        ack_d = 1'b0;
        wr_ign_d = 1'b0;
        if (i_ce) begin
            if (rd_clear) begin
                // Capture uses the old flags; clearing lands on the same edge
                rdata_d = RCF_UNDEF_FILL;
                rdata_d[RCF_BIT_TRAP] = flags_q[RCF_SRC_TRAP];
                rdata_d[RCF_BIT_WDT] = flags_q[RCF_SRC_WDT];
                rdata_d[RCF_BIT_LVD] = flags_q[RCF_SRC_LVD];
                ack_d = 1'b1;
            end
            // Writes have no effect; flagged so a driver bug is visible
            wr_ign_d = i_bus_wr && hit;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags_q <= RCF_FLAGS_RESET;
            rdata_q <= RCF_RDATA_RESET;
            ack_q <= 1'b0;
            wr_ign_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            wr_ign_q <= wr_ign_d;
        end
    end

    assign o_bus_rdata = rdata_q;
    assign o_bus_ack = ack_q;
    assign o_bus_wr_ignored = wr_ign_q;
    assign o_trap_reset = trap;
    assign o_flags = flags_q;
endmodule

// File: rtl/rcf_trap_detect.sv
// Illegal opcode detector that raises the trap reset request
`timescale 1ns/10ps
module rcf_trap_detect
    import rcf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_exec_valid,
    input wire logic [7:0] i_exec_opcode,
    input wire logic i_emulation,
    output logic o_trap
);
    logic trap_q;
    logic trap_d;

    always_comb begin
        trap_d = trap_q;
        if (i_ce) begin
            // Under a debug emulator the opcode is a break, not a reset
            trap_d = i_exec_valid && (i_exec_opcode == RCF_ILLEGAL_OPCODE)
                     && !i_emulation;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trap_q <= 1'b0;
        end else begin
            trap_q <= trap_d;
        end
    end

    assign o_trap = trap_q;
endmodule

// File: test/rcf_top_monitor.sv
// Port checker for the reset cause flag block
`timescale 1ns/10ps
module rcf_top_monitor
    import rcf_pkg::*;
(
    input wire logic i_clk, i_rst, i_ce, i_reset_pin, i_wdt_reset, i_lvd_reset,
    input wire logic i_exec_valid, i_emulation, i_bus_rd, i_bus_wr, o_bus_ack,
    input wire logic o_bus_wr_ignored, o_trap_reset,
    input wire logic [7:0] i_exec_opcode, o_bus_rdata,
    input wire logic [19:0] i_bus_addr,
    input wire logic [2:0] o_flags
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire rh = i_ce && i_bus_rd && i_bus_addr == RCF_ADDR;
    wire go = i_ce && !i_reset_pin;
    wire wh = i_ce && i_bus_wr && i_bus_addr == RCF_ADDR;
    wire tx = i_ce && i_exec_valid && i_exec_opcode == RCF_ILLEGAL_OPCODE;
    read_ack_a: assert property (rh |=> o_bus_ack) else $error("ack");
    read_data_a: assert property (rh |=> o_bus_rdata == {$past(o_flags[2]),
        2'h0, $past(o_flags[1]), 3'h0, $past(o_flags[0])}) else $error("rdata");
    pin_clear_a: assert property (i_ce && i_reset_pin |=> o_flags == 3'h0)
        else $error("pin");
    wdt_set_a: assert property (go && i_wdt_reset |=> o_flags[1]) else $error("wdt");
    lvd_set_a: assert property (go && i_lvd_reset |=> o_flags[0]) else $error("lvd");
    trap_req_a: assert property (tx && !i_emulation |=> o_trap_reset) else $error("trap");
    trap_flag_a: assert property (o_trap_reset && go |=> o_flags[2]) else $error("flag");
    emu_quiet_a: assert property (tx && i_emulation |=> !o_trap_reset) else $error("emu");
    read_clear_a: assert property (rh && go && !i_wdt_reset && !i_lvd_reset
        && !o_trap_reset |=> o_flags == 3'h0) else $error("clear");
    write_flag_a: assert property (wh |=> o_bus_wr_ignored) else $error("wr");
    cover property (o_bus_ack && o_bus_rdata[7]);
    cover property (o_trap_reset);
    cover property (rh ##1 rh);
endmodule
bind rcf_top rcf_top_monitor rcf_top_monitor_inst (.*);

// File: test/tb.sv
// Random bench for the reset cause flag block
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
    import rcf_pkg::*;
    logic i_clk = 0, i_rst = 1, rd = 0, ack, wig, trp, ce = 1;
    logic [5:0] s = 0;
    logic [7:0] op = 0, rdata, e;
    logic [19:0] adr = RCF_ADDR;
    logic [2:0] m = 0, flags;
    logic [7:0] q[$];
    int error_cnt = 0, n_checks = 0;
    always #12.5 i_clk = ~i_clk;
    rcf_top rcf_top_inst (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_reset_pin(s[5]),
        .i_wdt_reset(s[4]), .i_lvd_reset(s[3]), .i_exec_valid(s[2]), .i_exec_opcode(op),
        .i_emulation(s[1]), .i_bus_addr(adr), .i_bus_rd(rd), .i_bus_wr(s[0]),
        .o_bus_rdata(rdata), .o_bus_ack(ack), .o_bus_wr_ignored(wig), .o_trap_reset(trp),
        .o_flags(flags));
    task automatic conclude;
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Back-to-back strobes: only the first read of a burst may see set flags
    // Every read is a whole byte strobe, never a bit access
    task automatic rdt(input int n);
        rd = 1;
        repeat (n) begin
            if (adr == RCF_ADDR) q.push_back({m[2], 2'h0, m[1], 3'h0, m[0]});
            if (adr == RCF_ADDR) m = 0;
            @(negedge i_clk);
        end
        rd = 0;
    endtask
    // A stray answer pops an unknown note and so always mismatches
    always @(negedge i_clk) if (ack) begin
        e = q.size() ? q.pop_front() : 8'hxx;
        `CHK("rdata", e, rdata)
    end
    initial begin
        void'($urandom(32'hE4CCD9DE));
        repeat (3) @(negedge i_clk);
        i_rst = 0;
        // Detector default start is not modelled, so bit 0 starts clear
        rdt(1);
        for (int k = 0; k < 80; k++) begin
            s = $urandom;
            s[5] = s[5] & s[0];
            s[2] = s[2] & !s[5];
            op = $urandom_range(1) ? 8'hFF : 8'($urandom);
            if (s[5]) m = 0;
            else m |= {s[2] && op == 8'hFF && !s[1], s[4], s[3]};
            @(negedge i_clk);
            s = 0;
            repeat (2) @(negedge i_clk);
            adr = k % 5 == 4 ? RCF_ADDR + 20'h1 : RCF_ADDR;
            if (k % 2) rdt(k % 3 + 1);
        end
        // Clock enable low: sources and a read must leave no trace
        adr = RCF_ADDR;
        ce = 0;
        s = 6'h18;
        rd = 1;
        @(negedge i_clk);
        rd = 0;
        s = 0;
        ce = 1;
        rdt(1);
        s = 6'h18;
        @(negedge i_clk);
        s = 0;
        i_rst = 1;
        @(negedge i_clk);
        i_rst = 0;
        m = 0;
        adr = RCF_ADDR;
        rdt(1);
        repeat (3) @(negedge i_clk);
        conclude();
    end
    initial begin
        #50us;
        error_cnt++;
        conclude();
    end
endmodule
